// file: logic/rxl_line_tap.sv
// Receive line input stage with data link tap
`timescale 1ns/1ps
`include "rxl_defs.svh"
module rxl_line_tap #(
    parameter int CNT_WIDTH = 16
) (
    // System clock and reset
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    // Configuration, system domain
    input wire logic rx_bipolar_format_sel,
    input wire logic violation_count_disable,
    input wire logic e1_mode,
    input wire logic [31:0] slot_select,
    input wire logic [7:0] slot_bit_select,
    input wire logic counter_clear,
    // Line interface, line clock domain
    input wire logic rx_line_clock_in,
    input wire logic rx_pos_rail_in,
    input wire logic rx_neg_rail_in,
    input wire logic rx_nrz_data_in,
    input wire logic rx_frame_sync,
    // Line side outputs
    output logic rx_nrz_line_data,
    output logic rx_link_data_out,
    output logic rx_link_gapped_clock,
    output logic rx_clock_out,
    // Status, system domain
    output logic [CNT_WIDTH-1:0] violation_count,
    output logic [CNT_WIDTH-1:0] invalid_count,
    output logic config_busy
);

    // Last bit position of the frame for the current line type
    function automatic logic [8:0] frame_last(input logic e1);
        frame_last = e1 ? `RXL_E1_FRAME_LAST : `RXL_T1_FRAME_LAST;
    endfunction

    // Whether a frame bit belongs to the tapped slots and bits
    function automatic logic bit_selected(
        input logic [8:0] pos,
        input logic e1,
        input logic [31:0] slots,
        input logic [7:0] bits
    );
        logic [8:0] offset;
        logic [4:0] slot;
        logic [2:0] bit_in_slot;
        offset = e1 ? pos : pos - `RXL_T1_FBIT_COUNT;
        slot = offset[`RXL_SLOT_MSB:`RXL_SLOT_LSB];
        bit_in_slot = offset[`RXL_SLOT_LSB-1:0];
        if (!e1 && pos == `RXL_T1_FBIT_POS)
            bit_selected = 1'b0;
        else
            bit_selected = slots[slot] & bits[bit_in_slot];
    endfunction

    // Saturating counter step with clear; an event in the clear cycle counts as one
    function automatic logic [CNT_WIDTH-1:0] count_step(
        input logic [CNT_WIDTH-1:0] value,
        input logic event_in,
        input logic clear
    );
        if (clear)
            count_step = event_in ? CNT_WIDTH'(1) : '0;
        else if (event_in && value != {CNT_WIDTH{1'b1}})
            count_step = value + CNT_WIDTH'(1);
        else
            count_step = value;
    endfunction

    // ------------------------------------------------------------
    // System domain: configuration hand-over
    // ------------------------------------------------------------
    rxl_pkg::rxl_cfg_state_t cfg_state;
    rxl_pkg::rxl_cfg_state_t next_cfg_state;
    logic held_format;
    logic held_lcv_dis;
    logic held_e1;
    logic [31:0] held_slots;
    logic [7:0] held_bits;
    logic cfg_req;
    logic cfg_ack_sys;
    logic cfg_changed;

    assign cfg_changed = (held_format != rx_bipolar_format_sel)
        || (held_lcv_dis != violation_count_disable)
        || (held_e1 != e1_mode)
        || (held_slots != slot_select)
        || (held_bits != slot_bit_select);

    always_comb
    begin
        next_cfg_state = cfg_state;
        case (cfg_state)
            rxl_pkg::cfg_idle:
                if (cfg_changed)
                    next_cfg_state = rxl_pkg::cfg_wait;
            rxl_pkg::cfg_wait:
                if (cfg_ack_sys == cfg_req)
                    next_cfg_state = rxl_pkg::cfg_idle;
            default:
                next_cfg_state = rxl_pkg::cfg_idle;
        endcase
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cfg_state <= rxl_pkg::cfg_idle;
            config_busy <= 1'b0;
        end
        else if (clock_enable)
        begin
            cfg_state <= next_cfg_state;
            config_busy <= (next_cfg_state == rxl_pkg::cfg_wait);
        end
    end

    // Held words stay still while a request is open, so the line
    // side may read them once it sees the toggle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            held_format <= `RXL_FORMAT_RST;
            held_lcv_dis <= `RXL_LCV_DIS_RST;
            held_e1 <= `RXL_E1_RST;
            held_slots <= `RXL_SLOT_SEL_RST;
            held_bits <= `RXL_BIT_SEL_RST;
            cfg_req <= 1'b0;
        end
        else if (clock_enable)
        begin
            if (cfg_state == rxl_pkg::cfg_idle && cfg_changed)
            begin
                held_format <= rx_bipolar_format_sel;
                held_lcv_dis <= violation_count_disable;
                held_e1 <= e1_mode;
                held_slots <= slot_select;
                held_bits <= slot_bit_select;
                cfg_req <= ~cfg_req;
            end
        end
    end

    // ------------------------------------------------------------
    // Line domain reset: asserts at once, releases on the line clock
    // ------------------------------------------------------------
    logic line_rst_a;
    logic line_rst;

    always_ff @(posedge rx_line_clock_in or posedge rst)
    begin
        if (rst)
        begin
            line_rst_a <= 1'b1;
            line_rst <= 1'b1;
        end
        else
        begin
            line_rst_a <= 1'b0;
            line_rst <= line_rst_a;
        end
    end

    // ------------------------------------------------------------
    // Line domain: configuration take-over
    // ------------------------------------------------------------
    logic cfg_req_line;
    logic cfg_ack;
    logic line_format;
    logic line_lcv_dis;
    logic line_e1;
    logic [31:0] line_slots;
    logic [7:0] line_bits;

    rxl_sync2 #(
        .WIDTH(1)
    ) u_req_sync (
        .clock(rx_line_clock_in),
        .rst(line_rst),
        .clock_enable(1'b1),
        .d(cfg_req),
        .q(cfg_req_line)
    );

    always_ff @(posedge rx_line_clock_in or posedge line_rst)
    begin
        if (line_rst)
        begin
            cfg_ack <= 1'b0;
            line_format <= `RXL_FORMAT_RST;
            line_lcv_dis <= `RXL_LCV_DIS_RST;
            line_e1 <= `RXL_E1_RST;
            line_slots <= `RXL_SLOT_SEL_RST;
            line_bits <= `RXL_BIT_SEL_RST;
        end
        else if (cfg_req_line != cfg_ack)
        begin
            cfg_ack <= cfg_req_line;
            line_format <= held_format;
            line_lcv_dis <= held_lcv_dis;
            line_e1 <= held_e1;
            line_slots <= held_slots;
            line_bits <= held_bits;
        end
    end

    rxl_sync2 #(
        .WIDTH(1)
    ) u_ack_sync (
        .clock(clock),
        .rst(rst),
        .clock_enable(clock_enable),
        .d(cfg_ack),
        .q(cfg_ack_sys)
    );

    // ------------------------------------------------------------
    // Line domain: sampling and decoding
    // ------------------------------------------------------------
    logic pulse_now;
    logic invalid_now;
    logic have_polarity;
    logic last_polarity;
    logic violation_now;
    logic violation_toggle;
    logic invalid_toggle;
    logic [8:0] bit_pos;

    // Rails decode
    assign pulse_now = rx_pos_rail_in | rx_neg_rail_in;
    // Both rails high
    assign invalid_now = rx_pos_rail_in & rx_neg_rail_in;
    // Two valid pulses in a row of one polarity break alternation
    assign violation_now = pulse_now && !invalid_now && have_polarity
        && (last_polarity == rx_pos_rail_in);

    always_ff @(posedge rx_line_clock_in or posedge line_rst)
    begin
        if (line_rst)
            rx_nrz_line_data <= 1'b0;
        else if (line_format == rxl_pkg::fmt_rails)
            rx_nrz_line_data <= pulse_now;
        else
            rx_nrz_line_data <= rx_nrz_data_in;
    end

    // Polarity history and code error events
    always_ff @(posedge rx_line_clock_in or posedge line_rst)
    begin
        if (line_rst)
        begin
            have_polarity <= 1'b0;
            last_polarity <= 1'b0;
            violation_toggle <= 1'b0;
            invalid_toggle <= 1'b0;
        end
        else if (line_format == rxl_pkg::fmt_rails)
        begin
            if (pulse_now && !invalid_now)
            begin
                have_polarity <= 1'b1;
                last_polarity <= rx_pos_rail_in;
            end
            if (violation_now && !line_lcv_dis)
                violation_toggle <= ~violation_toggle;
            if (invalid_now)
                invalid_toggle <= ~invalid_toggle;
        end
        else
            have_polarity <= 1'b0;
    end

    // Position of the bit now held in the line data flop
    always_ff @(posedge rx_line_clock_in or posedge line_rst)
    begin
        if (line_rst)
            bit_pos <= 9'h000;
        else if (rx_frame_sync || bit_pos >= frame_last(line_e1))
            bit_pos <= 9'h000;
        else
            bit_pos <= bit_pos + 9'h001;
    end

    // ------------------------------------------------------------
    // Line domain: data link tap on the falling edge
    // ------------------------------------------------------------
    logic link_select;

    always_ff @(negedge rx_line_clock_in or posedge line_rst)
    begin
        if (line_rst)
        begin
            rx_link_data_out <= 1'b0;
            link_select <= 1'b0;
        end
        else
        begin
            rx_link_data_out <= rx_nrz_line_data;
            link_select <= bit_selected(bit_pos, line_e1, line_slots,
                line_bits);
        end
    end

    assign rx_clock_out = rx_line_clock_in;
    assign rx_link_gapped_clock = link_select & ~rx_line_clock_in;

    // ------------------------------------------------------------
    // System domain: error counters
    // ------------------------------------------------------------
    logic [1:0] event_sys;
    logic [1:0] event_seen;
    logic [1:0] event_pulse;

    rxl_sync2 #(
        .WIDTH(2)
    ) u_event_sync (
        .clock(clock),
        .rst(rst),
        .clock_enable(clock_enable),
        .d({invalid_toggle, violation_toggle}),
        .q(event_sys)
    );

    assign event_pulse = event_sys ^ event_seen;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            event_seen <= 2'b00;
        else if (clock_enable)
            event_seen <= event_sys;
    end

    // Counters saturate rather than wrap so a long burst is not hidden
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            violation_count <= CNT_WIDTH'(`RXL_CNT_RST);
            invalid_count <= CNT_WIDTH'(`RXL_CNT_RST);
        end
        else if (clock_enable)
        begin
            violation_count <= count_step(violation_count,
                event_pulse[0], counter_clear);
            invalid_count <= count_step(invalid_count,
                event_pulse[1], counter_clear);
        end
    end

endmodule

// file: logic/rxl_defs.svh
// Constants for the receive line input and data link tap
`ifndef RXL_DEFS_SVH
`define RXL_DEFS_SVH

// Frame lengths in line bits, stored as last position (length - 1)
`define RXL_T1_FRAME_LAST 9'h0C0
`define RXL_E1_FRAME_LAST 9'h0FF
// T1 frames open with one framing bit ahead of slot zero
`define RXL_T1_FBIT_POS 9'h000
`define RXL_T1_FBIT_COUNT 9'h001
// Bit position of the slot number inside a frame offset
`define RXL_SLOT_LSB 3
`define RXL_SLOT_MSB 7

// Reset values of the configuration bundle and the counters, and counter full scale
`define RXL_FORMAT_RST 1'b1
`define RXL_LCV_DIS_RST 1'b0
`define RXL_E1_RST 1'b0
`define RXL_SLOT_SEL_RST 32'h0000_0000
`define RXL_BIT_SEL_RST 8'hFF
`define RXL_CNT_RST 16'h0000
`define RXL_CNT_MAX 16'hFFFF

`endif

// file: logic/rxl_pkg.sv
// Types for the receive line input and data link tap
package rxl_pkg;

    // Configuration hand-over state, one-hot
    typedef enum logic [1:0] {
        cfg_idle = 2'b01,
        cfg_wait = 2'b10
    } rxl_cfg_state_t;

    // Receive input format
    typedef enum logic {
        fmt_nrz = 1'b0,
        fmt_rails = 1'b1
    } rxl_format_t;

endpackage

// file: logic/rxl_sync2.sv
// Two flip-flop synchroniser with clock enable
`timescale 1ns/1ps
module rxl_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset of the receiving domain
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    // Data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage_a;

    // First stage is read by the second stage only
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            stage_a <= '0;
            q <= '0;
        end
        else if (clock_enable)
        begin
            stage_a <= d;
            q <= stage_a;
        end
    end

endmodule

// file: verification/rxl_line_tap_monitor.sv
// Port checker for the receive line tap, bound to its top module
`timescale 1ns/1ps
module rxl_line_tap_monitor #(
    parameter int CNT_WIDTH = 16
) (
    // System side
    input wire logic clock,
    input wire logic rst,
    input wire logic clock_enable,
    input wire logic rx_bipolar_format_sel,
    input wire logic violation_count_disable,
    input wire logic e1_mode,
    input wire logic [31:0] slot_select,
    input wire logic [7:0] slot_bit_select,
    input wire logic counter_clear,
    // Line side
    input wire logic rx_line_clock_in,
    input wire logic rx_pos_rail_in,
    input wire logic rx_neg_rail_in,
    input wire logic rx_nrz_data_in,
    input wire logic rx_frame_sync,
    // Outputs
    input wire logic rx_nrz_line_data,
    input wire logic rx_link_data_out,
    input wire logic rx_link_gapped_clock,
    input wire logic rx_clock_out,
    input wire logic [CNT_WIDTH-1:0] violation_count,
    input wire logic [CNT_WIDTH-1:0] invalid_count,
    input wire logic config_busy
);
    logic [42:0] cfg_v;
    logic [4:0] quiet;
    logic cfg_ok;

    // Line copy of config trusted only once idle and unchanged a while
    assign cfg_v = {rx_bipolar_format_sel, violation_count_disable, e1_mode,
        slot_select, slot_bit_select};
    assign cfg_ok = &quiet;
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            quiet <= 5'h00;
        else if (config_busy || !clock_enable || !$stable(cfg_v))
            quiet <= 5'h00;
        else if (!cfg_ok)
            quiet <= quiet + 5'h01;
    end

    rail_decode_a:
    assert property (@(posedge rx_line_clock_in) disable iff (rst)
        cfg_ok && rx_bipolar_format_sel |=> rx_nrz_line_data ==
        ($past(rx_pos_rail_in) | $past(rx_neg_rail_in)))
        else $error("rail decode wrong");
    nrz_take_a:
    assert property (@(posedge rx_line_clock_in) disable iff (rst)
        cfg_ok && !rx_bipolar_format_sel |=>
        rx_nrz_line_data == $past(rx_nrz_data_in))
        else $error("nrz bit wrong");
    // Increment lands well inside one line bit, so step is exact
    invalid_cnt_a:
    assert property (@(posedge rx_line_clock_in) disable iff (rst)
        cfg_ok && rx_bipolar_format_sel && clock_enable && !counter_clear
        && !(&invalid_count) |=> counter_clear
        || (invalid_count - $past(invalid_count) ==
        ($past(rx_pos_rail_in) & $past(rx_neg_rail_in))))
        else $error("invalid count step wrong");
    viol_off_a:
    assert property (@(posedge clock) disable iff (rst)
        cfg_ok && violation_count_disable && !counter_clear
        |=> $stable(violation_count))
        else $error("violation counted while disabled");
    link_copy_a:
    assert property (@(negedge rx_line_clock_in) disable iff (rst)
        1'b1 |=> rx_link_data_out == $past(rx_nrz_line_data))
        else $error("link data not a copy");
    gap_phase_a:
    assert property (@(posedge clock) disable iff (rst)
        rx_line_clock_in |-> !rx_link_gapped_clock)
        else $error("gapped clock high in high phase");
    gap_none_a:
    assert property (@(posedge clock) disable iff (rst)
        cfg_ok && slot_select == 32'h0000_0000 |-> !rx_link_gapped_clock)
        else $error("gapped clock with no slot");
    gap_all_a:
    assert property (@(posedge clock) disable iff (rst)
        cfg_ok && e1_mode && (&slot_select) && (&slot_bit_select)
        && !rx_line_clock_in |-> rx_link_gapped_clock)
        else $error("gapped clock missing");
    clk_follow_a:
    assert property (@(posedge clock) disable iff (rst)
        rx_clock_out == rx_line_clock_in)
        else $error("clock out not following");

    viol_seen_c: cover property (@(posedge clock) disable iff (rst)
        $rose(violation_count[0]));
    gap_seen_c: cover property (@(posedge clock) disable iff (rst)
        $rose(rx_link_gapped_clock));
    busy_seen_c: cover property (@(posedge clock) disable iff (rst)
        $rose(config_busy));
endmodule

bind rxl_line_tap rxl_line_tap_monitor #(.CNT_WIDTH(CNT_WIDTH))
    rxl_line_tap_monitor_i (.*);

// file: verification/rxl_liu_model.sv
// Line interface unit model: free-running line clock and data
`timescale 1ns/1ps
module rxl_liu_model (
    // Toward the tap
    output logic rx_line_clock_in,
    output logic rx_pos_rail_in,
    output logic rx_neg_rail_in,
    output logic rx_nrz_data_in,
    output logic rx_frame_sync
);
    // Recovered clock runs free; odd offset keeps it off system edges
    initial
    begin
        rx_line_clock_in = 1'b0;
        {rx_pos_rail_in, rx_neg_rail_in, rx_nrz_data_in, rx_frame_sync} = 4'h0;
        #3.3;
        forever #16 rx_line_clock_in = ~rx_line_clock_in;
    end

    // one bit held across its sampling rise
    task automatic send(input logic [3:0] v);
        @(negedge rx_line_clock_in);
        #1;
        {rx_pos_rail_in, rx_neg_rail_in, rx_nrz_data_in, rx_frame_sync} = v;
    endtask
endmodule

// file: verification/tb.sv
// Testbench for the receive line tap
`timescale 1ns/1ps
module tb;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic fmt = 1'b1;
    logic dis = 1'b0;
    logic e1 = 1'b0;
    logic [31:0] slots = 32'h0000_0000;
    logic [7:0] bits = 8'hFF;
    logic clr = 1'b0;
    logic lclk, pos, neg, nrz, fs;
    logic nrz_o, link_o, gap_o, ck_o, busy;
    logic [2:0] viol, inv;
    logic armed, prev_d, prev_g;
    int err_total = 0;
    int n_compared = 0;

    always #2.5 clock = ~clock;

    rxl_liu_model rxl_liu_model_i (.rx_line_clock_in(lclk),
        .rx_pos_rail_in(pos), .rx_neg_rail_in(neg),
        .rx_nrz_data_in(nrz), .rx_frame_sync(fs));
    // Narrow counters so saturation is reachable
    rxl_line_tap #(.CNT_WIDTH(3)) rxl_line_tap_i (
        .clock(clock), .rst(rst), .clock_enable(1'b1),
        .rx_bipolar_format_sel(fmt), .violation_count_disable(dis),
        .e1_mode(e1), .slot_select(slots), .slot_bit_select(bits),
        .counter_clear(clr), .rx_line_clock_in(lclk),
        .rx_pos_rail_in(pos), .rx_neg_rail_in(neg),
        .rx_nrz_data_in(nrz), .rx_frame_sync(fs),
        .rx_nrz_line_data(nrz_o), .rx_link_data_out(link_o),
        .rx_link_gapped_clock(gap_o), .rx_clock_out(ck_o),
        .violation_count(viol), .invalid_count(inv), .config_busy(busy));

    task automatic chk(input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test;
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic tap(input int p, input logic m,
        input logic [31:0] s, input logic [7:0] b);
        if (!m && p == 0)
            return 1'b0;
        if (!m)
            p = p - 1;
        return s[p / 8] & b[p % 8];
    endfunction

    task automatic set_cfg(input logic f, d, m, input logic [31:0] s,
        input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clock);
        {fmt, dis, e1, slots, bits} = {f, d, m, s, b};
        @(negedge clock);
        @(negedge clock);
        chk(busy, 16'h0001);
        while (busy !== 1'b0 && n < 80)
        begin
            @(negedge clock);
            n++;
        end
        chk(16'(n), 16'(n % 80));
        armed = 1'b0;
    endtask

    // One line bit; link side of the previous bit judged at this fall
    task automatic bit1(input logic [3:0] v, input logic d, g);
        rxl_liu_model_i.send(v);
        if (armed)
        begin
            chk(link_o, prev_d);
            chk(gap_o, prev_g);
        end
        @(posedge lclk);
        #1;
        chk(nrz_o, d);
        chk(ck_o, lclk);
        prev_d = d;
        prev_g = g;
        armed = 1'b1;
    endtask

    task automatic t_pulses;
        logic [3:0] seq [8] = '{4'h8, 4'h4, 4'h8, 4'h8,
            4'h4, 4'h4, 4'hC, 4'h4};
        armed = 1'b0;
        foreach (seq[i]) bit1(seq[i], |seq[i][3:2], 1'b0);
        repeat (2) bit1(4'h0, 1'b0, 1'b0);
        chk(viol, 16'h0003);
        chk(inv, 16'h0001);
    endtask

    task automatic t_unipolar;
        logic [3:0] seq [5] = '{4'h8, 4'h8, 4'h0, 4'h8, 4'hC};
        set_cfg(1'b1, 1'b1, 1'b0, 32'h0000_0000, 8'hFF);
        foreach (seq[i]) bit1(seq[i], seq[i][3], 1'b0);
        repeat (2) bit1(4'h0, 1'b0, 1'b0);
        chk(viol, 16'h0003);
        chk(inv, 16'h0002);
        @(negedge clock);
        // Clear spans two line rises so the line-clocked check sees it
        clr = 1'b1;
        repeat (16) @(negedge clock);
        clr = 1'b0;
        @(negedge clock);
        chk({viol, inv}, 16'h0000);
        set_cfg(1'b1, 1'b0, 1'b0, 32'h0000_0000, 8'hFF);
        repeat (10) bit1(4'h8, 1'b1, 1'b0);
        repeat (2) bit1(4'h0, 1'b0, 1'b0);
        chk(viol, 16'h0007);
    endtask

    // Rails carry junk in NRZ mode; they must be ignored
    task automatic frame_run(input logic m, input logic [31:0] s,
        input logic [7:0] b, input int n);
        int p;
        logic d;
        set_cfg(1'b0, 1'b0, m, s, b);
        for (int i = 0; i < n; i++)
        begin
            p = i % (m ? 256 : 193);
            d = i[0] ^ i[2];
            bit1({~d, d, d, i == 0}, d, tap(p, m, s, b));
        end
    endtask

    initial
    begin
        repeat (16) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        chk({viol, inv, nrz_o, link_o, gap_o, busy}, 16'h0000);
        repeat (3) @(posedge lclk);
        t_pulses;
        t_unipolar;
        frame_run(1'b0, 32'h0000_0002, 8'h81, 204);
        frame_run(1'b1, 32'h8000_0001, 8'h01, 260);
        frame_run(1'b1, 32'hFFFF_FFFF, 8'hFF, 20);
        end_of_test;
    end

    // About 20 us of traffic expected; ten times that means a hang
    initial
    begin
        #200000;
        err_total++;
        end_of_test;
    end
endmodule
